/* File: shared/dcsr_pkg.sv */
// Constants for the second compressor control and effects status registers.
// Assumes a 32-bit APB slave with 16-bit byte addresses.
`default_nettype none

package dcsr_pkg;

	localparam int DCSR_ADDR_W = 16;
	localparam int DCSR_DATA_W = 32;

	// Byte addresses
	localparam logic [15:0] DCSR_EFFECTS_PATH_STATUS_OFFS = 16'ha804;
	localparam logic [15:0] DCSR_PATH_EN_OFFS = 16'ha808;
	localparam logic [15:0] DCSR_CTRL_OFFS = 16'hab18;

	// Effects status field and path indices inside it
	localparam int DCSR_FX_LSB = 4;
	localparam int DCSR_FX_W = 12;
	localparam logic [11:0] DCSR_FX_RST = 12'h000;
	localparam logic [11:0] DCSR_COMP_PATH_MASK = 12'h0f0;
	localparam int DCSR_PATH_REJECT_BIT = 16;

	// Control word fields
	localparam int DCSR_ATK_LSB = 28;
	localparam int DCSR_DCY_LSB = 24;
	localparam int DCSR_MIN_LSB = 18;
	localparam int DCSR_MAX_LSB = 16;
	localparam int DCSR_RMS_LSB = 11;
	localparam int DCSR_PK_LSB = 9;
	localparam int DCSR_NG_BIT = 8;
	localparam int DCSR_MODE_BIT = 7;
	localparam int DCSR_SIGDET_BIT = 6;
	localparam int DCSR_KNEE2_BIT = 5;
	localparam int DCSR_QR_BIT = 4;
	localparam int DCSR_ACLIP_BIT = 3;

	localparam logic [3:0] DCSR_ATK_RST = 4'h4;
	localparam logic [3:0] DCSR_DCY_RST = 4'h9;
	localparam logic [2:0] DCSR_MIN_RST = 3'h4;
	localparam logic [1:0] DCSR_MAX_RST = 2'h3;
	localparam logic [4:0] DCSR_RMS_RST = 5'h00;
	localparam logic [1:0] DCSR_PK_RST = 2'h0;
	localparam logic DCSR_NG_RST = 1'b0;
	localparam logic DCSR_MODE_RST = 1'b0;
	localparam logic DCSR_SIGDET_RST = 1'b0;
	localparam logic DCSR_KNEE2_RST = 1'b0;
	localparam logic DCSR_QR_RST = 1'b1;
	localparam logic DCSR_ACLIP_RST = 1'b1;

	localparam logic [31:0] DCSR_CTRL_RST = {DCSR_ATK_RST, DCSR_DCY_RST, 3'h0,
		DCSR_MIN_RST, DCSR_MAX_RST, DCSR_RMS_RST, DCSR_PK_RST, DCSR_NG_RST,
		DCSR_MODE_RST, DCSR_SIGDET_RST, DCSR_KNEE2_RST, DCSR_QR_RST,
		DCSR_ACLIP_RST, 3'h0};
	// Bits 23:21 and 2:0 are not stored
	localparam logic [31:0] DCSR_CTRL_MASK = 32'hff1ffff8;

	// Nearest defined codes for the processing side
	localparam logic [3:0] DCSR_ATK_LOWEST = 4'h1;
	localparam logic [3:0] DCSR_ATK_HIGHEST = 4'hb;
	localparam logic [3:0] DCSR_DCY_HIGHEST = 4'hb;
	localparam logic [2:0] DCSR_MIN_HIGHEST = 3'h4;

endpackage : dcsr_pkg

`default_nettype wire

/* File: design/dcsr_code_clamp.sv */
// Maps reserved rate and gain codes onto the nearest defined setting.
// Purely combinational; the caller registers the results.
`timescale 1ns/1ps
`default_nettype none

module dcsr_code_clamp (
	input wire logic [3:0] atk_raw,
	input wire logic [3:0] dcy_raw,
	input wire logic [2:0] min_raw,
	output logic [3:0] atk_eff,
	output logic [3:0] dcy_eff,
	output logic [2:0] min_eff
);
	import dcsr_pkg::*;

	always_comb begin
		// Code 0 sits below the fastest attack, codes above 1011 beyond the slowest
		if (atk_raw < DCSR_ATK_LOWEST) begin
			atk_eff = DCSR_ATK_LOWEST;
		end else if (atk_raw > DCSR_ATK_HIGHEST) begin
			atk_eff = DCSR_ATK_HIGHEST;
		end else begin
			atk_eff = atk_raw;
		end
		dcy_eff = (dcy_raw > DCSR_DCY_HIGHEST) ? DCSR_DCY_HIGHEST : dcy_raw;
		min_eff = (min_raw > DCSR_MIN_HIGHEST) ? DCSR_MIN_HIGHEST : min_raw;
	end

endmodule : dcsr_code_clamp

`default_nettype wire

/* File: design/dcsr_regs.sv */
// APB register slice for the second compressor: effects status, path enables
// and the dynamics control word.
// Assumes the clock monitor drives system_clock_too_slow on pclk.
//
// Contract
// - Effects status bits 15:4 read-only
// - Status bit order: EQ, compressors, filters
// - Attack rate bits 31:28, reset 0100
// - Decay rate bits 27:24, reset 1001
// - Minimum gain bits 20:18, reset 100
// - Maximum gain bits 17:16, reset 11
// - RMS threshold bits 15:11, reset 0
// - Peak threshold bits 10:9, reset 0
// - Detect mode bit 7, reset 0
// - Single-bit enables with their reset values
// - Refuse compressor enable when clock slow
`timescale 1ns/1ps
`default_nettype none

module dcsr_regs (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [dcsr_pkg::DCSR_ADDR_W-1:0] paddr,
	input wire logic [dcsr_pkg::DCSR_DATA_W-1:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [dcsr_pkg::DCSR_DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic system_clock_too_slow,
	output logic [dcsr_pkg::DCSR_FX_W-1:0] path_enable,
	output logic enable_rejected,
	output logic [3:0] gain_attack_rate,
	output logic [3:0] gain_decay_rate,
	output logic [2:0] minimum_gain_sel,
	output logic [1:0] maximum_gain_sel,
	output logic [4:0] detect_rms_threshold,
	output logic [1:0] detect_peak_threshold,
	output logic noise_gate_enable,
	output logic detect_mode_select,
	output logic signal_detect_enable,
	output logic second_knee_output_enable,
	output logic quick_release_enable,
	output logic anticlip_enable
);
	import dcsr_pkg::*;

	typedef struct packed {
		logic [31:0] ctrl;
		logic [11:0] path_en;
		logic rejected;
		logic [3:0] atk_eff;
		logic [3:0] dcy_eff;
		logic [2:0] min_eff;
		logic [31:0] rdata;
		logic slverr;
	} dcsr_state_s;

	localparam dcsr_state_s DCSR_STATE_RST = '{
		ctrl: DCSR_CTRL_RST,
		path_en: DCSR_FX_RST,
		rejected: 1'b0,
		atk_eff: DCSR_ATK_RST,
		dcy_eff: DCSR_DCY_RST,
		min_eff: DCSR_MIN_RST,
		rdata: 32'h0000_0000,
		slverr: 1'b0
	};

	dcsr_state_s state_q;
	dcsr_state_s state_d;

	logic setup_phase;
	logic access_wr;
	logic wr_ctrl;
	logic wr_path;
	logic [31:0] ctrl_next;
	logic [31:0] path_word;
	logic [31:0] path_written;
	logic [11:0] path_req;
	logic [11:0] path_rising;
	logic [11:0] path_allowed;
	logic reject_evt;
	logic reject_clr;
	logic [3:0] atk_clamped;
	logic [3:0] dcy_clamped;
	logic [2:0] min_clamped;

	function automatic logic [31:0] dcsr_merge(
		input logic [31:0] old_v,
		input logic [31:0] new_v,
		input logic [3:0] strb
	);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[8*i +: 8] = new_v[8*i +: 8];
			end
		end
		return r;
	endfunction : dcsr_merge

	// Zero wait states: data for the access phase is latched during setup
	assign pready = 1'b1;
	assign setup_phase = psel && !penable;
	assign access_wr = psel && penable && pwrite;
	assign wr_ctrl = access_wr && (paddr == DCSR_CTRL_OFFS);
	assign wr_path = access_wr && (paddr == DCSR_PATH_EN_OFFS);

	// Reserved field codes are kept as written, only unused bits dropped
	assign ctrl_next = wr_ctrl ? (dcsr_merge(state_q.ctrl, pwdata, pstrb) & DCSR_CTRL_MASK)
		: state_q.ctrl;

	assign path_word = {15'h0000, state_q.rejected, 4'h0, state_q.path_en};
	assign path_written = dcsr_merge(path_word, pwdata, pstrb);
	assign path_req = wr_path ? path_written[11:0] : state_q.path_en;
	assign path_rising = path_req & ~state_q.path_en;
	// Running paths and disables always pass; only new compressor enables can be refused
	assign path_allowed = system_clock_too_slow ? ~(path_rising & DCSR_COMP_PATH_MASK)
		: 12'hfff;
	assign reject_evt = |(path_rising & DCSR_COMP_PATH_MASK) && system_clock_too_slow;
	assign reject_clr = wr_path && pstrb[2] && pwdata[DCSR_PATH_REJECT_BIT];

	dcsr_code_clamp u_clamp (
		.atk_raw(ctrl_next[DCSR_ATK_LSB +: 4]),
		.dcy_raw(ctrl_next[DCSR_DCY_LSB +: 4]),
		.min_raw(ctrl_next[DCSR_MIN_LSB +: 3]),
		.atk_eff(atk_clamped),
		.dcy_eff(dcy_clamped),
		.min_eff(min_clamped)
	);

	always_comb begin
		state_d = state_q;
		state_d.ctrl = ctrl_next;
		state_d.atk_eff = atk_clamped;
		state_d.dcy_eff = dcy_clamped;
		state_d.min_eff = min_clamped;
		state_d.path_en = path_req & path_allowed;
		// A refusal in the clearing cycle still leaves the flag set
		state_d.rejected = reject_evt || (state_q.rejected && !reject_clr);
		if (setup_phase) begin
			state_d.rdata = 32'h0000_0000;
			state_d.slverr = 1'b0;
			unique case (paddr)
				DCSR_EFFECTS_PATH_STATUS_OFFS: begin
					// Status is read-only; a write is flagged and has no effect
					state_d.rdata[DCSR_FX_LSB +: DCSR_FX_W] = state_q.path_en;
					state_d.slverr = pwrite;
				end
				DCSR_PATH_EN_OFFS: begin
					state_d.rdata = pwrite ? 32'h0000_0000 : path_word;
				end
				DCSR_CTRL_OFFS: begin
					state_d.rdata = pwrite ? 32'h0000_0000 : state_q.ctrl;
				end
				default: begin
					state_d.slverr = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= DCSR_STATE_RST;
		end else begin
			state_q <= state_d;
		end
	end

	assign prdata = state_q.rdata;
	assign pslverr = state_q.slverr;
	assign path_enable = state_q.path_en;
	assign enable_rejected = state_q.rejected;
	assign gain_attack_rate = state_q.atk_eff;
	assign gain_decay_rate = state_q.dcy_eff;
	assign minimum_gain_sel = state_q.min_eff;
	assign maximum_gain_sel = state_q.ctrl[DCSR_MAX_LSB +: 2];
	assign detect_rms_threshold = state_q.ctrl[DCSR_RMS_LSB +: 5];
	assign detect_peak_threshold = state_q.ctrl[DCSR_PK_LSB +: 2];
	assign noise_gate_enable = state_q.ctrl[DCSR_NG_BIT];
	assign detect_mode_select = state_q.ctrl[DCSR_MODE_BIT];
	assign signal_detect_enable = state_q.ctrl[DCSR_SIGDET_BIT];
	assign second_knee_output_enable = state_q.ctrl[DCSR_KNEE2_BIT];
	assign quick_release_enable = state_q.ctrl[DCSR_QR_BIT];
	assign anticlip_enable = state_q.ctrl[DCSR_ACLIP_BIT];

endmodule : dcsr_regs

`default_nettype wire

/* File: verification/dcsr_clk_mon.sv */
// Stand-in for the clock monitor that flags a too-slow system clock.
// Assumes the bench moves slow_req between bus transfers.
`timescale 1ns/1ps
`default_nettype none
module dcsr_clk_mon (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic slow_req,
	output logic system_clock_too_slow
);
	// Registered, as a real monitor judges whole cycles
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) system_clock_too_slow <= 1'b0;
		else system_clock_too_slow <= slow_req;
	end
endmodule : dcsr_clk_mon
`default_nettype wire

/* File: verification/dcsr_regs_sva.sv */
// Port checks for the compressor two register slice.
// Assumes one pclk domain and zero-wait APB.
`timescale 1ns/1ps
`default_nettype none
module dcsr_regs_sva (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	input wire logic system_clock_too_slow,
	input wire logic [11:0] path_enable,
	input wire logic enable_rejected,
	input wire logic [3:0] gain_attack_rate,
	input wire logic [3:0] gain_decay_rate,
	input wire logic [2:0] minimum_gain_sel,
	input wire logic quick_release_enable,
	input wire logic anticlip_enable
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire wr = psel && penable && pwrite && paddr == 16'ha808;
	AST_STATUS_RO: assert property (psel && !penable && pwrite
		&& paddr == 16'ha804 |=> pslverr) else $error("status write not refused");
	AST_STATUS_MAP: assert property (psel && !penable && !pwrite && paddr == 16'ha804
		|=> prdata == {16'h0000, $past(path_enable), 4'h0}) else $error("status word wrong");
	AST_REFUSE: assert property (wr && system_clock_too_slow
		|=> (path_enable[7:4] & ~$past(path_enable[7:4])) == 4'h0) else $error("slow enable taken");
	AST_REJ_FLAG: assert property (wr && system_clock_too_slow && pstrb[0]
		&& |(pwdata[7:4] & ~path_enable[7:4]) |=> enable_rejected) else $error("no reject flag");
	AST_ATK: assert property (gain_attack_rate inside {[4'h1:4'hb]})
		else $error("attack code undefined");
	AST_DCY: assert property (gain_decay_rate <= 4'hb)
		else $error("decay code undefined");
	AST_MIN: assert property (minimum_gain_sel <= 3'h4)
		else $error("min gain undefined");
	AST_RST: assert property ($rose(presetn) |-> quick_release_enable && anticlip_enable)
		else $error("enable reset wrong");
endmodule : dcsr_regs_sva
bind dcsr_regs dcsr_regs_sva chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.pstrb, .prdata, .pslverr, .system_clock_too_slow, .path_enable, .enable_rejected,
	.gain_attack_rate, .gain_decay_rate, .minimum_gain_sel, .quick_release_enable, .anticlip_enable);
`default_nettype wire

/* File: verification/compressor_two_control_status_regs_tb.sv */
// Bench for the compressor two register slice over APB.
// Assumes the clock monitor model drives the slow-clock flag.
`timescale 1ns/1ps
`default_nettype none
module compressor_two_control_status_regs_tb;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slow_req = 0, slow, e;
	logic [15:0] paddr = 16'h0000;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic [3:0] pstrb = 4'hf, atk, dcy;
	logic pready, pslverr, rej, ng, mode, sd, k2, qr, ac;
	logic [11:0] pe;
	logic [2:0] mn;
	logic [1:0] mx, pk;
	logic [4:0] rms;
	int err_total = 0, n_checks = 0, cyc = 0;
	always #4 pclk = ~pclk;
	dcsr_clk_mon mon (.pclk, .presetn, .slow_req, .system_clock_too_slow(slow));
	dcsr_regs dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
		.pready, .pslverr, .system_clock_too_slow(slow), .path_enable(pe), .enable_rejected(rej),
		.gain_attack_rate(atk), .gain_decay_rate(dcy), .minimum_gain_sel(mn),
		.maximum_gain_sel(mx), .detect_rms_threshold(rms), .detect_peak_threshold(pk),
		.noise_gate_enable(ng), .detect_mode_select(mode), .signal_detect_enable(sd),
		.second_knee_output_enable(k2), .quick_release_enable(qr), .anticlip_enable(ac));
	task automatic chk(input logic [31:0] seen, input logic [31:0] want);
		n_checks++;
		if (seen !== want) begin
			err_total++;
			$display("FAIL %0t: got %h want %h", $time, seen, want);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
		input logic [3:0] s);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic conclude();
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : conclude
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 2000) begin
			err_total++;
			conclude();
		end
	end
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk({atk, dcy, mn}, {4'h4, 4'h9, 3'h4});
		chk({mx, rms, pk, ng, mode, sd, k2, qr, ac}, 15'h6003);
		chk({rej, pe}, 13'h0000);
		apb(0, 16'hab18, 0, 4'hf);
		chk(r, 32'h49130018);
		apb(1, 16'hab18, 32'h0c1ffff8, 4'hf);
		@(posedge pclk);
		chk({atk, dcy, mn}, {4'h1, 4'hb, 3'h4});
		chk({mx, rms, pk, ng, mode, sd, k2, qr, ac}, 15'h7fff);
		apb(0, 16'hab18, 0, 4'hf);
		chk(r, 32'h0c1ffff8);
		// Only the low byte lane may move
		apb(1, 16'hab18, 32'h0, 4'h1);
		apb(0, 16'hab18, 0, 4'hf);
		chk(r, 32'h0c1fff00);
		apb(1, 16'ha808, 32'h00000fff, 4'hf);
		apb(0, 16'ha804, 0, 4'hf);
		chk(r, 32'h0000fff0);
		apb(1, 16'ha804, 32'h0, 4'hf);
		chk(e, 1'b1);
		apb(0, 16'ha804, 0, 4'hf);
		chk(r, 32'h0000fff0);
		apb(1, 16'ha808, 32'h00000010, 4'hf);
		slow_req <= 1'b1;
		apb(1, 16'ha808, 32'h00000fff, 4'hf);
		@(posedge pclk);
		chk({rej, pe}, 13'h1f1f);
		slow_req <= 1'b0;
		apb(0, 16'ha800, 0, 4'hf);
		chk(e, 1'b1);
		chk(r, 32'h0000_0000);
		apb(0, 16'ha808, 0, 4'hf);
		chk(r, 32'h00010f1f);
		// Writing one to the flag clears it; no path may move
		apb(1, 16'ha808, 32'h00010f1f, 4'hf);
		chk(e, 1'b0);
		apb(0, 16'ha808, 0, 4'hf);
		chk(r, 32'h00000f1f);
		// Reserved codes above the defined range
		apb(1, 16'hab18, 32'hf5140018, 4'hf);
		@(posedge pclk);
		chk({atk, dcy, mn}, {4'hb, 4'h5, 3'h4});
		apb(0, 16'hab18, 0, 4'hf);
		chk(r, 32'hf5140018);
		// Reset in mid-run brings every field back
		presetn <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b1;
		apb(0, 16'hab18, 0, 4'hf);
		chk(r, 32'h49130018);
		chk({rej, pe}, 13'h0000);
		conclude();
	end
endmodule : compressor_two_control_status_regs_tb
`default_nettype wire
